// ### shared/rhp_pkg.sv
// Constants and types for the root hub port status and power block
package rhp_pkg;

  // Port count and register placement
  localparam int RHP_NUM_PORTS = 2;
  localparam int RHP_ADDR_W = 8;
  localparam int RHP_DATA_W = 32;
  localparam logic [7:0] RHP_PORT_BASE = 8'h54;
  localparam logic [7:0] RHP_PORT_STRIDE = 8'h04;

  // Field positions inside the port word
  localparam int RHP_BIT_CONNECT = 0;
  localparam int RHP_BIT_ENABLE = 1;
  localparam int RHP_BIT_SUSPEND = 2;
  localparam int RHP_BIT_OVERCUR = 3;
  localparam int RHP_BIT_RESET = 4;
  localparam int RHP_BIT_POWER = 8;
  localparam int RHP_BIT_LOWSPD = 9;
  localparam int RHP_BIT_CONN_CHG = 16;

  // Reset values
  localparam logic RHP_POWER_RST = 1'b0;
  localparam logic RHP_CONN_CHG_RST = 1'b0;
  localparam logic RHP_CLEAR_RST = 1'b0;
  localparam logic RHP_EDGE_RST = 1'b0;
  localparam logic [31:0] RHP_WORD_RST = 32'h00000000;

  // Root hub reset reporting sequence, Gray coded
  typedef enum logic [1:0] {
    RHP_ST_BOOT = 2'b00,
    RHP_ST_REPORT = 2'b01,
    RHP_ST_RUN = 2'b11
  } rhp_state_t;

endpackage : rhp_pkg

// ### logic/rhp_edge.sv
// Level change detector for one port signal
`timescale 1ns/1ps
module rhp_edge
  import rhp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched level
  input wire logic level,
  // Change pulses
  output logic rise,
  output logic fall
);

  logic prev_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_r <= RHP_EDGE_RST;
    end else begin
      prev_r <= level;
    end
  end

  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;

endmodule : rhp_edge

// ### logic/rhp_top.sv
// Root hub per-port connect change, low speed and power status logic
//
// Summary of operation
// - Attach or detach on a removable port sets that port's connect change flag, bit 16.
// - Writing one to bit 16 clears the flag; writing zero leaves it.
// - Reset, enable or suspend write to an unconnected port sets the connect change flag.
// - Non-removable ports set the connect change flag once after a root hub reset if connected, not on attach or detach.
// - Bit 9 reads one for a low-speed device, zero for full-speed.
// - Writing one to bit 9 turns port power off, subject to scheme; zero does nothing.
// - Bit 8 reads the actual port power state under either switching scheme.
// - Overcurrent clears the port power status.
// - Switching scheme zero: only global power commands change port power.
// - Scheme one with mask set: only per-port power commands act on this port.
// - Scheme one with mask clear: only global power commands act on this port.
// - Power turning off pulses PORT_STATUS_CLEAR so neighbouring logic resets connect, enable, suspend and reset status bits.
// - Writing one to bit 8 turns port power on, subject to scheme; zero does nothing.
`timescale 1ns/1ps
module rhp_top
  import rhp_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register access
  input wire logic [RHP_ADDR_W-1:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [RHP_DATA_W-1:0] REG_WDATA,
  output logic [RHP_DATA_W-1:0] REG_RDATA,
  output logic REG_RD_ACK,
  // Root hub configuration
  input wire logic SWITCH_SCHEME_SELECT,
  input wire logic [RHP_NUM_PORTS-1:0] PER_PORT_POWER_MASK,
  input wire logic [RHP_NUM_PORTS-1:0] NONREMOVABLE_MARKER,
  // Global power strobes
  input wire logic ALL_PORTS_POWER_ON_CMD,
  input wire logic ALL_PORTS_POWER_OFF_CMD,
  // Status from neighbouring port logic and the port
  input wire logic [RHP_NUM_PORTS-1:0] PORT_CONNECT_STATUS,
  input wire logic [RHP_NUM_PORTS-1:0] PORT_ENABLE_STATUS,
  input wire logic [RHP_NUM_PORTS-1:0] PORT_SUSPEND_STATUS,
  input wire logic [RHP_NUM_PORTS-1:0] PORT_RESET_STATUS,
  input wire logic [RHP_NUM_PORTS-1:0] PORT_OVERCURRENT,
  input wire logic [RHP_NUM_PORTS-1:0] LOW_SPEED_ATTACHED,
  // Port outputs
  output logic [RHP_NUM_PORTS-1:0] PORT_POWER_STATUS,
  output logic [RHP_NUM_PORTS-1:0] PORT_STATUS_CLEAR,
  output logic [RHP_NUM_PORTS-1:0] CONNECT_CHANGE_FLAG
);

  rhp_state_t state_r;
  rhp_state_t state_nxt;
  logic report_pulse;
  logic [RHP_NUM_PORTS-1:0] wr_hit;
  logic [RHP_NUM_PORTS-1:0] rd_hit;
  logic [RHP_NUM_PORTS-1:0] conn_chg_r;
  logic [RHP_NUM_PORTS-1:0] pps_r;
  logic [RHP_NUM_PORTS-1:0] clear_r;
  logic [RHP_DATA_W-1:0] port_word [RHP_NUM_PORTS];
  logic [RHP_DATA_W-1:0] rdata_nxt;
  logic rd_any;

  // Reporting sequence after root hub reset
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RHP_ST_BOOT: begin
        state_nxt = RHP_ST_REPORT;
      end
      RHP_ST_REPORT: begin
        state_nxt = RHP_ST_RUN;
      end
      RHP_ST_RUN: begin
        state_nxt = RHP_ST_RUN;
      end
      default: begin
        state_nxt = RHP_ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_r <= RHP_ST_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign report_pulse = (state_r == RHP_ST_REPORT);

  // One copy of the port logic per downstream port
  generate
    for (genvar i = 0; i < RHP_NUM_PORTS; i++) begin : g_port
      localparam logic [7:0] PORT_ADDR = 8'(RHP_PORT_BASE + 8'(i) * RHP_PORT_STRIDE);

      logic attach;
      logic detach;
      logic conn_event;
      logic dead_port_write;
      logic conn_set;
      logic conn_clr;
      logic global_ok;
      logic local_ok;
      logic pwr_on;
      logic pwr_off;
      logic pps_nxt;

      assign wr_hit[i] = REG_WR && (REG_ADDR == PORT_ADDR);
      assign rd_hit[i] = REG_RD && (REG_ADDR == PORT_ADDR);

      rhp_edge u_conn_edge (
        .clk(REF_CLK),
        .rst(RST),
        .level(PORT_CONNECT_STATUS[i]),
        .rise(attach),
        .fall(detach)
      );

      // Removable ports report plug events, fixed ports report once after reset
      assign conn_event = NONREMOVABLE_MARKER[i] ?
                          (report_pulse && PORT_CONNECT_STATUS[i]) :
                          (attach || detach);

      assign dead_port_write = wr_hit[i] && !PORT_CONNECT_STATUS[i] &&
                               (REG_WDATA[RHP_BIT_RESET] || REG_WDATA[RHP_BIT_ENABLE] ||
                                REG_WDATA[RHP_BIT_SUSPEND]);

      assign conn_set = conn_event || dead_port_write;
      assign conn_clr = wr_hit[i] && REG_WDATA[RHP_BIT_CONN_CHG];

      // Set wins over a clear in the same cycle
      always_ff @(posedge REF_CLK) begin
        if (RST) begin
          conn_chg_r[i] <= RHP_CONN_CHG_RST;
        end else if (conn_set) begin
          conn_chg_r[i] <= 1'b1;
        end else if (conn_clr) begin
          conn_chg_r[i] <= 1'b0;
        end
      end

      // Which power command source this port obeys
      assign local_ok = SWITCH_SCHEME_SELECT && PER_PORT_POWER_MASK[i];
      assign global_ok = !SWITCH_SCHEME_SELECT || !PER_PORT_POWER_MASK[i];

      assign pwr_on = (local_ok && wr_hit[i] && REG_WDATA[RHP_BIT_POWER]) ||
                      (global_ok && ALL_PORTS_POWER_ON_CMD);
      assign pwr_off = (local_ok && wr_hit[i] && REG_WDATA[RHP_BIT_LOWSPD]) ||
                       (global_ok && ALL_PORTS_POWER_OFF_CMD) ||
                       PORT_OVERCURRENT[i];

      // Off and overcurrent take priority over on
      always_comb begin
        pps_nxt = pps_r[i];
        if (pwr_off) begin
          pps_nxt = 1'b0;
        end else if (pwr_on) begin
          pps_nxt = 1'b1;
        end
      end

      always_ff @(posedge REF_CLK) begin
        if (RST) begin
          pps_r[i] <= RHP_POWER_RST;
        end else begin
          pps_r[i] <= pps_nxt;
        end
      end

      // Pulse that tells the neighbouring status logic to drop its bits
      always_ff @(posedge REF_CLK) begin
        if (RST) begin
          clear_r[i] <= RHP_CLEAR_RST;
        end else begin
          clear_r[i] <= pps_r[i] && !pps_nxt;
        end
      end

      // Read view of the port word
      always_comb begin
        port_word[i] = RHP_WORD_RST;
        port_word[i][RHP_BIT_CONNECT] = PORT_CONNECT_STATUS[i];
        port_word[i][RHP_BIT_ENABLE] = PORT_ENABLE_STATUS[i];
        port_word[i][RHP_BIT_SUSPEND] = PORT_SUSPEND_STATUS[i];
        port_word[i][RHP_BIT_OVERCUR] = PORT_OVERCURRENT[i];
        port_word[i][RHP_BIT_RESET] = PORT_RESET_STATUS[i];
        port_word[i][RHP_BIT_POWER] = pps_r[i];
        port_word[i][RHP_BIT_LOWSPD] = LOW_SPEED_ATTACHED[i];
        port_word[i][RHP_BIT_CONN_CHG] = conn_chg_r[i];
      end
    end
  endgenerate

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rdata_nxt = RHP_WORD_RST;
    for (int k = 0; k < RHP_NUM_PORTS; k++) begin
      if (rd_hit[k]) begin
        rdata_nxt = rdata_nxt | port_word[k];
      end
    end
  end

  assign rd_any = REG_RD;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      REG_RDATA <= RHP_WORD_RST;
      REG_RD_ACK <= 1'b0;
    end else begin
      REG_RD_ACK <= rd_any;
      if (rd_any) begin
        REG_RDATA <= rdata_nxt;
      end
    end
  end

  // Registered port outputs
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PORT_POWER_STATUS <= {RHP_NUM_PORTS{RHP_POWER_RST}};
      PORT_STATUS_CLEAR <= {RHP_NUM_PORTS{RHP_CLEAR_RST}};
      CONNECT_CHANGE_FLAG <= {RHP_NUM_PORTS{RHP_CONN_CHG_RST}};
    end else begin
      PORT_POWER_STATUS <= pps_r;
      PORT_STATUS_CLEAR <= clear_r;
      CONNECT_CHANGE_FLAG <= conn_chg_r;
    end
  end

endmodule : rhp_top

// ### tb/rhp_chk.sv
// Assertions on the root hub port status block
`timescale 1ns/1ps
module rhp_chk
  import rhp_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register access
  input wire logic [RHP_ADDR_W-1:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [RHP_DATA_W-1:0] REG_WDATA,
  input wire logic [RHP_DATA_W-1:0] REG_RDATA,
  input wire logic REG_RD_ACK,
  // Port side
  input wire logic [RHP_NUM_PORTS-1:0] NONREMOVABLE_MARKER,
  input wire logic [RHP_NUM_PORTS-1:0] PORT_CONNECT_STATUS,
  input wire logic [RHP_NUM_PORTS-1:0] PORT_OVERCURRENT,
  input wire logic [RHP_NUM_PORTS-1:0] LOW_SPEED_ATTACHED,
  input wire logic [RHP_NUM_PORTS-1:0] PORT_POWER_STATUS,
  input wire logic [RHP_NUM_PORTS-1:0] PORT_STATUS_CLEAR,
  input wire logic [RHP_NUM_PORTS-1:0] CONNECT_CHANGE_FLAG
);
  logic rd0_r;
  logic clr0;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  assign clr0 = REG_WR && REG_WDATA[RHP_BIT_CONN_CHG] && REG_ADDR == RHP_PORT_BASE;
  // Port 0 read in flight
  always_ff @(posedge REF_CLK) begin
    rd0_r <= REG_RD && REG_ADDR == RHP_PORT_BASE;
  end
  chk_rd_ack: assert property (REG_RD_ACK == $past(REG_RD))
    else $error("read ack wrong");
  chk_oc_power: assert property (|PORT_OVERCURRENT |-> ##2 !(PORT_POWER_STATUS & $past(PORT_OVERCURRENT, 2)))
    else $error("power stays on overcurrent");
  chk_off_clear: assert property (PORT_STATUS_CLEAR == ($past(PORT_POWER_STATUS) & ~PORT_POWER_STATUS))
    else $error("status clear wrong");
  chk_flag_clear: assert property ($fell(CONNECT_CHANGE_FLAG[0]) |-> $past(clr0, 2))
    else $error("flag fell unasked");
  chk_attach_flag: assert property ($changed(PORT_CONNECT_STATUS[1]) && !NONREMOVABLE_MARKER[1] |-> ##[1:4] CONNECT_CHANGE_FLAG[1])
    else $error("no flag on attach");
  chk_low_speed: assert property (REG_RD_ACK && rd0_r |-> REG_RDATA[9] == $past(LOW_SPEED_ATTACHED[0]))
    else $error("speed bit wrong");
  chk_power_read: assert property (REG_RD_ACK && rd0_r |-> REG_RDATA[8] == PORT_POWER_STATUS[0])
    else $error("power bit wrong");
  chk_flag_read: assert property (REG_RD_ACK && rd0_r |-> REG_RDATA[16] == CONNECT_CHANGE_FLAG[0])
    else $error("flag bit wrong");
  cover property ($rose(CONNECT_CHANGE_FLAG[1]));
  cover property (|PORT_STATUS_CLEAR);
  cover property (PORT_OVERCURRENT[0] ##2 !PORT_POWER_STATUS[0]);
endmodule : rhp_chk

// ### tb/rhp_dev_model.sv
// Behavioural devices on the downstream ports
`timescale 1ns/1ps
module rhp_dev_model
  import rhp_pkg::*;
(
  // Clock and hub side
  input wire logic clk,
  input wire logic rst,
  input wire logic [RHP_NUM_PORTS-1:0] clr,
  // Bench controls
  input wire logic [RHP_NUM_PORTS-1:0] plug,
  input wire logic [RHP_NUM_PORTS-1:0] slow,
  input wire logic [RHP_NUM_PORTS-1:0] fault,
  // Port status
  output logic [RHP_NUM_PORTS-1:0] conn,
  output logic [RHP_NUM_PORTS-1:0] lsa,
  output logic [RHP_NUM_PORTS-1:0] oc
);
  logic [RHP_NUM_PORTS-1:0] plug_r = '0;
  logic [RHP_NUM_PORTS-1:0] conn_r = '0;
  // Attach on plug-in; power-off clear drops it until replugged
  // Reset keeps an unknown clear pulse out of the connect state
  always_ff @(posedge clk) begin
    if (rst) begin
      plug_r <= '0;
      conn_r <= '0;
    end else begin
      plug_r <= plug;
      conn_r <= (conn_r | (plug & ~plug_r)) & plug & ~clr;
    end
  end
  assign conn = conn_r;
  assign lsa = slow & conn_r;
  assign oc = fault;
endmodule : rhp_dev_model

// ### tb/rhp_top_test.sv
// Self-checking bench for the root hub port status block
`timescale 1ns/1ps
module rhp_top_test
  import rhp_pkg::*;
;
  logic REF_CLK = 1'h0, RST = 1'h1, REG_WR = 1'h0, REG_RD = 1'h0, REG_RD_ACK, SWITCH_SCHEME_SELECT = 1'h0;
  logic ALL_PORTS_POWER_ON_CMD = 1'h0, ALL_PORTS_POWER_OFF_CMD = 1'h0;
  logic [RHP_ADDR_W-1:0] REG_ADDR = '0;
  logic [RHP_DATA_W-1:0] REG_WDATA = '0, REG_RDATA;
  logic [RHP_NUM_PORTS-1:0] PER_PORT_POWER_MASK = '0, NONREMOVABLE_MARKER = 2'h1, plug = 2'h1, slow = '0;
  logic [RHP_NUM_PORTS-1:0] fault = '0, PORT_SUSPEND_STATUS = '0, PORT_RESET_STATUS = '0;
  logic [RHP_NUM_PORTS-1:0] PORT_CONNECT_STATUS, PORT_ENABLE_STATUS, PORT_OVERCURRENT, LOW_SPEED_ATTACHED;
  logic [RHP_NUM_PORTS-1:0] PORT_POWER_STATUS, PORT_STATUS_CLEAR, CONNECT_CHANGE_FLAG;
  int err_count = 0;
  int n_compared = 0;
  int bits[3] = '{1, 2, 4};
  rhp_top dut (.*);
  rhp_dev_model u_dev (.clk(REF_CLK), .rst(RST), .clr(PORT_STATUS_CLEAR), .plug(plug), .slow(slow), .fault(fault),
    .conn(PORT_CONNECT_STATUS), .lsa(LOW_SPEED_ATTACHED), .oc(PORT_OVERCURRENT));
  assign PORT_ENABLE_STATUS = PORT_CONNECT_STATUS;
  always #2.5 REF_CLK = ~REF_CLK;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'h1;
    idle(1);
    REG_WR = 1'h0;
    idle(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    REG_ADDR = a;
    REG_RD = 1'h1;
    idle(1);
    REG_RD = 1'h0;
    chk("ack", {31'h0, REG_RD_ACK}, 32'h1);
    chk("word", REG_RDATA, exp);
    idle(1);
  endtask : rd
  task automatic pul(input logic on);
    ALL_PORTS_POWER_ON_CMD = on;
    ALL_PORTS_POWER_OFF_CMD = ~on;
    idle(1);
    ALL_PORTS_POWER_ON_CMD = 1'h0;
    ALL_PORTS_POWER_OFF_CMD = 1'h0;
    idle(4);
  endtask : pul
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    #20000;
    err_count++;
    end_of_test();
  end
  initial begin
    idle(20);
    RST = 1'h0;
    idle(3);
    rd(8'h54, 32'h0001_0003);
    rd(8'h60, 32'h0);
    wr(8'h54, 32'h0);
    rd(8'h54, 32'h0001_0003);
    wr(8'h54, 32'h0001_0000);
    rd(8'h54, 32'h3);
    plug = 2'h0;
    idle(4);
    rd(8'h54, 32'h0);
    $display("t1 done");
    foreach (bits[k]) begin
      wr(8'h58, 32'h1 << bits[k]);
      rd(8'h58, 32'h0001_0000);
      wr(8'h58, 32'h0001_0000);
    end
    $display("t2 done");
    slow = 2'h2;
    plug = 2'h2;
    idle(4);
    rd(8'h58, 32'h0001_0203);
    wr(8'h58, 32'h0001_0000);
    plug = 2'h0;
    idle(4);
    rd(8'h58, 32'h0001_0000);
    wr(8'h58, 32'h0001_0000);
    $display("t3 done");
    wr(8'h54, 32'h100);
    rd(8'h54, 32'h0);
    pul(1'h1);
    rd(8'h54, 32'h100);
    rd(8'h58, 32'h100);
    wr(8'h54, 32'h200);
    rd(8'h54, 32'h100);
    $display("t4 done");
    SWITCH_SCHEME_SELECT = 1'h1;
    PER_PORT_POWER_MASK = 2'h1;
    wr(8'h58, 32'h200);
    rd(8'h58, 32'h100);
    plug = 2'h2;
    idle(4);
    wr(8'h58, 32'h0001_0000);
    pul(1'h0);
    rd(8'h54, 32'h100);
    rd(8'h58, 32'h0001_0000);
    wr(8'h54, 32'h200);
    rd(8'h54, 32'h0);
    wr(8'h54, 32'h100);
    rd(8'h54, 32'h100);
    wr(8'h58, 32'h100);
    rd(8'h58, 32'h0001_0000);
    $display("t5 done");
    fault = 2'h1;
    idle(2);
    fault = 2'h0;
    idle(2);
    rd(8'h54, 32'h0);
    $display("t6 done");
    end_of_test();
  end
endmodule : rhp_top_test
bind rhp_top rhp_chk u_chk (.*);
